// File: core/smc_socket_mode.sv
// per-socket mode registers, receive filter and acknowledge timing
`timescale 1ns/1ns
`include "smc_cfg.svh"
module smc_socket_mode #(
    parameter int NUM_SOCK = 8,
    parameter int UNIT_CYC = (`SMC_UNIT_NS * `SMC_CLK_MHZ) / 1000
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire smc_pkg::smc_acc_s acc_i,
    input wire logic [15:0] retry_interval_i,
    input wire smc_pkg::smc_rx_s rx_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic rx_accept_o,
    output logic rx_drop_o,
    output logic [7:0] ack_send_o,
    output logic [7:0] igmp_sel_o,
    output logic [63:0] sock_status_o
);
    import smc_pkg::*;

    // socket count is bounded by the three-bit index
    if (NUM_SOCK < 1 || NUM_SOCK > 8) begin : g_chk_n
        $error("NUM_SOCK must be 1 to 8");
    end
    if (UNIT_CYC < 1 || UNIT_CYC > 4096) begin : g_chk_u
        $error("UNIT_CYC must be 1 to 4096");
    end

    localparam logic [3:0] NS4 = 4'(NUM_SOCK);
    localparam logic [11:0] UNIT_LAST = 12'(UNIT_CYC - 1);

    ////////////////////////////////////////////////////////////////////
    // storage
    logic [7:0] mode_r [NUM_SOCK];     // mode register per socket
    logic [7:0] stat_r [NUM_SOCK];     // socket state after open/close
    logic ack_r [NUM_SOCK];            // one-cycle ack request
    logic igmp_r [NUM_SOCK];           // selected igmp version
    smc_ack_e ack_st_r [NUM_SOCK];     // ack scheduler state
    logic [15:0] ack_cnt_r [NUM_SOCK]; // remaining retry units
    logic [11:0] unit_cnt_r;           // prescaler for retry unit
    logic unit_tick_r;                 // one pulse per retry unit

    // access decode, shared by all sockets
    logic acc_ok;
    logic wr_mode;
    logic wr_cmd;
    assign acc_ok = acc_i.valid && ({1'b0, acc_i.socket} < NS4);
    assign wr_mode = acc_ok && acc_i.write && (acc_i.offset == `SMC_MODE_OFS);
    assign wr_cmd = acc_ok && acc_i.write && (acc_i.offset == `SMC_CMD_OFS);

    ////////////////////////////////////////////////////////////////////
    // retry unit prescaler, free running so the first unit of a delay may be partial
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            unit_cnt_r <= 12'h000;
            unit_tick_r <= 1'b0;
        end else if (unit_cnt_r == UNIT_LAST) begin
            unit_cnt_r <= 12'h000;
            unit_tick_r <= 1'b1;
        end else begin
            unit_cnt_r <= unit_cnt_r + 12'h001;
            unit_tick_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per-socket registers and acknowledge scheduling
    for (genvar i = 0; i < NUM_SOCK; i++) begin : g_sock
        localparam logic [2:0] IDX = 3'(i);
        logic sel;
        logic seg_in;
        assign sel = (acc_i.socket == IDX);
        assign seg_in = rx_i.valid && rx_i.tcp_data && (rx_i.socket == IDX) && (stat_r[i] == `SMC_ST_TCP);

        // mode register, plain read/write
        always_ff @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                mode_r[i] <= `SMC_MODE_RST;
            end else if (wr_mode && sel) begin
                mode_r[i] <= acc_i.wdata;
            end
        end

        // open latches the protocol held right now, close clears it
        always_ff @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                stat_r[i] <= `SMC_ST_CLOSED;
            end else if (wr_cmd && sel && acc_i.wdata == `SMC_CMD_OPEN) begin
                case (mode_r[i][3:0])
                    `SMC_PROTO_TCP: stat_r[i] <= `SMC_ST_TCP;
                    `SMC_PROTO_UDP: stat_r[i] <= `SMC_ST_UDP;
                    // raw only honoured on socket zero; elsewhere stays shut
                    `SMC_PROTO_RAW: stat_r[i] <= (i == 0) ? `SMC_ST_RAW : `SMC_ST_CLOSED;
                    default: stat_r[i] <= `SMC_ST_CLOSED;
                endcase
            end else if (wr_cmd && sel && acc_i.wdata == `SMC_CMD_CLOSE) begin
                stat_r[i] <= `SMC_ST_CLOSED;
            end
        end

        // igmp version bit only means something in UDP multicast mode, whether the socket is open or not
        always_ff @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                igmp_r[i] <= 1'b0;
            end else begin
                igmp_r[i] <= (mode_r[i][3:0] == `SMC_PROTO_UDP) && mode_r[i][`SMC_BIT7]
                             && mode_r[i][`SMC_BIT5];
            end
        end

        // ack scheduler: immediate or after the retry interval
        always_ff @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                ack_st_r[i] <= ACK_IDLE;
                ack_cnt_r[i] <= `SMC_RETRY_ZERO;
                ack_r[i] <= 1'b0;
            end else begin
                ack_r[i] <= 1'b0;
                case (ack_st_r[i])
                    ACK_IDLE: begin
                        if (seg_in && mode_r[i][`SMC_BIT5]) begin
                            ack_r[i] <= 1'b1;
                        end else if (seg_in) begin
                            ack_st_r[i] <= ACK_WAIT;
                            ack_cnt_r[i] <= retry_interval_i;
                        end
                    end
                    ACK_WAIT: begin
                        // a segment arriving meanwhile rides on the pending ack
                        if (unit_tick_r) begin
                            if (ack_cnt_r[i] == `SMC_RETRY_ZERO) begin
                                ack_r[i] <= 1'b1;
                                ack_st_r[i] <= ACK_IDLE;
                            end else begin
                                ack_cnt_r[i] <= ack_cnt_r[i] - 16'h0001;
                            end
                        end
                    end
                    default: ack_st_r[i] <= ACK_IDLE;
                endcase
            end
        end
    end

    // flatten per-socket flops onto the output buses
    always_comb begin
        ack_send_o = 8'h00;
        igmp_sel_o = 8'h00;
        sock_status_o = 64'h0;
        for (int k = 0; k < NUM_SOCK; k++) begin
            ack_send_o[k] = ack_r[k];
            igmp_sel_o[k] = igmp_r[k];
            sock_status_o[k*8 +: 8] = stat_r[k];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register read port, answer one cycle after the access
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= `SMC_ZERO8;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= acc_i.valid && !acc_i.write;
            if (acc_ok && !acc_i.write && acc_i.offset == `SMC_MODE_OFS) begin
                rd_data_o <= mode_r[acc_i.socket];
            end else if (acc_ok && !acc_i.write && acc_i.offset == `SMC_STAT_OFS) begin
                rd_data_o <= stat_r[acc_i.socket];
            end else begin
                // command register reads back cleared, unmapped reads zero
                rd_data_o <= `SMC_ZERO8;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receive filter, decided per packet on the addressed socket
    logic [7:0] rx_mode;
    logic [7:0] rx_stat;
    logic rx_pass;
    always_comb begin
        rx_mode = `SMC_ZERO8;
        rx_stat = `SMC_ST_CLOSED;
        if ({1'b0, rx_i.socket} < NS4) begin
            rx_mode = mode_r[rx_i.socket];
            rx_stat = stat_r[rx_i.socket];
        end
        case (rx_stat)
            `SMC_ST_TCP: rx_pass = 1'b1; // bit7 has no filter effect here
            `SMC_ST_UDP: begin
                rx_pass = !(rx_i.bcast && rx_mode[`SMC_BIT6]);
                if (rx_mode[`SMC_BIT7] && rx_mode[`SMC_BIT4] && rx_i.ip_unicast) begin
                    rx_pass = 1'b0;
                end
            end
            `SMC_ST_RAW: begin
                rx_pass = !(rx_mode[`SMC_BIT7] && !rx_i.bcast && !rx_i.own_mac);
                if (rx_i.bcast && rx_mode[`SMC_BIT6]) rx_pass = 1'b0;
                if (rx_i.grp_mac && rx_mode[`SMC_BIT5]) rx_pass = 1'b0;
                if (rx_i.ipv6 && rx_mode[`SMC_BIT4]) rx_pass = 1'b0;
            end
            default: rx_pass = 1'b0;
        endcase
    end

    // verdict is a one-cycle pulse after the packet descriptor
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_accept_o <= 1'b0;
            rx_drop_o <= 1'b0;
        end else begin
            rx_accept_o <= rx_i.valid && rx_pass;
            rx_drop_o <= rx_i.valid && !rx_pass;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence rx_udp_q;
        rx_i.valid && rx_stat == `SMC_ST_UDP;
    endsequence
    sequence rx_raw_q;
        rx_i.valid && rx_stat == `SMC_ST_RAW;
    endsequence
    sequence open_q;
        wr_cmd && acc_i.wdata == `SMC_CMD_OPEN;
    endsequence

    mode_write_a: assert property (wr_mode |=> mode_r[$past(acc_i.socket)] == $past(acc_i.wdata))
        else $error("mode write not stored");
    mode_read_a: assert property (acc_ok && !acc_i.write && acc_i.offset == `SMC_MODE_OFS && !wr_mode
        |=> rd_valid_o && rd_data_o == mode_r[$past(acc_i.socket)])
        else $error("mode read wrong");
    open_tcp_a: assert property (open_q and (mode_r[acc_i.socket][3:0] == `SMC_PROTO_TCP)
        |=> stat_r[$past(acc_i.socket)] == `SMC_ST_TCP)
        else $error("tcp open state wrong");
    open_udp_a: assert property (open_q and (mode_r[acc_i.socket][3:0] == `SMC_PROTO_UDP)
        |=> stat_r[$past(acc_i.socket)] == `SMC_ST_UDP)
        else $error("udp open state wrong");
    udp_bcast_a: assert property (rx_udp_q and (rx_i.bcast && rx_mode[`SMC_BIT6]) |=> rx_drop_o)
        else $error("udp broadcast passed");
    udp_ucast_a: assert property (rx_udp_q and (rx_i.ip_unicast && rx_mode[7:4] == 4'h1 && !rx_i.bcast)
        |=> rx_accept_o)
        else $error("unicast dropped without multicast");
    udp_single_a: assert property (rx_udp_q and (rx_i.ip_unicast && rx_mode[`SMC_BIT7]
        && rx_mode[`SMC_BIT4]) |=> rx_drop_o && !rx_accept_o)
        else $error("unicast passed in multicast");
    raw_filter_a: assert property (rx_raw_q and (rx_mode[`SMC_BIT7] && !rx_i.bcast && !rx_i.own_mac)
        |=> rx_drop_o)
        else $error("foreign frame passed filter");
    raw_ipv6_a: assert property (rx_raw_q and (rx_i.ipv6 && rx_mode[`SMC_BIT4]) |=> rx_drop_o)
        else $error("ipv6 frame passed");
    raw_group_a: assert property (rx_raw_q and (rx_i.grp_mac && rx_mode[`SMC_BIT5]) |=> rx_drop_o)
        else $error("group frame passed");
    ack_now_a: assert property (g_sock[0].seg_in && ack_st_r[0] == ACK_IDLE && mode_r[0][`SMC_BIT5]
        |=> ack_send_o[0])
        else $error("immediate ack missing");
    // a zero interval may ack at the very next unit tick, so only a nonzero one is held
    ack_hold_a: assert property (g_sock[0].seg_in && ack_st_r[0] == ACK_IDLE && !mode_r[0][`SMC_BIT5]
        && retry_interval_i != `SMC_RETRY_ZERO |=> !ack_send_o[0] ##1 !ack_send_o[0])
        else $error("delayed ack sent early");
endmodule

// File: core/smc_cfg.svh
// constants for the per-socket mode register bank
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH
// register offsets inside one socket's register space
`define SMC_MODE_OFS 16'h0000
`define SMC_CMD_OFS 16'h0001
`define SMC_STAT_OFS 16'h0003
// reset values
`define SMC_MODE_RST 8'h00
`define SMC_ZERO8 8'h00
// protocol selector codes, low nibble of the mode register
`define SMC_PROTO_CLOSED 4'h0
`define SMC_PROTO_TCP 4'h1
`define SMC_PROTO_UDP 4'h2
`define SMC_PROTO_RAW 4'h4
// option bit positions
`define SMC_BIT7 7
`define SMC_BIT6 6
`define SMC_BIT5 5
`define SMC_BIT4 4
// socket commands
`define SMC_CMD_OPEN 8'h01
`define SMC_CMD_CLOSE 8'h10
// socket state codes after open
`define SMC_ST_CLOSED 8'h00
`define SMC_ST_TCP 8'h13
`define SMC_ST_UDP 8'h22
`define SMC_ST_RAW 8'h42
// retry interval unit, clock rate
`define SMC_UNIT_NS 100000
`define SMC_CLK_MHZ 25
`define SMC_RETRY_ZERO 16'h0000
`endif

// File: core/smc_pkg.sv
// types shared by the socket mode register bank
package smc_pkg;
    // one register access from the host port, already framed
    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] socket;
        logic [15:0] offset;
        logic [7:0] wdata;
    } smc_acc_s;
    // classification of one received packet or frame
    typedef struct packed {
        logic valid;
        logic [2:0] socket;
        logic bcast;
        logic own_mac;
        logic grp_mac;
        logic ipv6;
        logic ip_unicast;
        logic tcp_data;
    } smc_rx_s;
    // acknowledge scheduler per socket
    typedef enum logic [0:0] {
        ACK_IDLE,
        ACK_WAIT
    } smc_ack_e;
endpackage

// File: verification/smc_host_model.sv
// host-side model that frames single-byte register accesses
`timescale 1ns/1ns
module smc_host_model
    import smc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rd_valid_i,
    input wire logic [7:0] rd_data_i,
    output smc_pkg::smc_acc_s acc_o
);
    ////////////////////////////////////////
    // idle until a task launches an access
    initial begin
        acc_o = '0;
    end
    // launch just after an edge, release after the taking edge
    // released fields go inverted so stale values never look valid
    task automatic access(input logic wr, input logic [2:0] s, input logic [15:0] o,
                          input logic [7:0] wd, output logic [7:0] rd, output logic ok);
        @(posedge mclk_i);
        #1;
        acc_o = '{valid: 1'b1, write: wr, socket: s, offset: o, wdata: wd};
        @(posedge mclk_i);
        #1;
        acc_o = '{valid: 1'b0, write: ~wr, socket: ~s, offset: ~o, wdata: ~wd};
        ok = rd_valid_i;
        rd = rd_data_i;
    endtask
endmodule

// File: verification/smc_socket_mode_tb_top.sv
// self-checking bench for the socket mode register bank
`timescale 1ns/1ns
`include "smc_cfg.svh"
module smc_socket_mode_tb_top;
    import smc_pkg::*;
    localparam int UNIT = 4; // short retry unit keeps the run brief
    localparam int RETRY = 2; // delayed ack length in units
    logic mclk;
    logic rst_n;
    smc_acc_s acc;
    smc_rx_s rx;
    logic [15:0] retry;
    logic [7:0] rd_data;
    logic rd_valid;
    logic rx_acc;
    logic rx_drop;
    logic [7:0] ack;
    logic [7:0] igmp;
    logic [63:0] status;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    ////////////////////////////////////////
    smc_socket_mode #(.NUM_SOCK(8), .UNIT_CYC(UNIT)) smc_socket_mode_i (.mclk_i(mclk), .rst_n_i(rst_n),
        .acc_i(acc), .retry_interval_i(retry), .rx_i(rx), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
        .rx_accept_o(rx_acc), .rx_drop_o(rx_drop), .ack_send_o(ack), .igmp_sel_o(igmp), .sock_status_o(status));
    smc_host_model smc_host_model_i (.mclk_i(mclk), .rd_valid_i(rd_valid), .rd_data_i(rd_data), .acc_o(acc));
    // 25 mhz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // hang guard, far above the cycles the tests need
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: timeout", $time);
            complete_run();
        end
    end
    ////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // compare one byte and count it
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // read must answer one cycle later
    task automatic reg_rd(input logic [2:0] s, input logic [15:0] o, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        smc_host_model_i.access(1'b0, s, o, 8'h00, d, ok);
        chk({7'h00, ok}, 8'h01, "read answer");
        chk(d, exp, "read data");
    endtask
    // a write never answers
    task automatic reg_wr(input logic [2:0] s, input logic [15:0] o, input logic [7:0] v);
        logic [7:0] d;
        logic ok;
        smc_host_model_i.access(1'b1, s, o, v, d, ok);
        chk({7'h00, ok}, 8'h00, "write answered");
    endtask
    // close, program mode, open; options alone would not reopen
    task automatic reopen(input logic [2:0] s, input logic [7:0] m);
        reg_wr(s, `SMC_CMD_OFS, `SMC_CMD_CLOSE);
        reg_wr(s, `SMC_MODE_OFS, m);
        reg_wr(s, `SMC_CMD_OFS, `SMC_CMD_OPEN);
    endtask
    // one-cycle descriptor, f is bcast own grp ipv6 unicast
    task automatic pkt(input logic [2:0] s, input logic [4:0] f, input logic seg);
        @(posedge mclk);
        #1;
        rx = {1'b1, s, f, seg};
        @(posedge mclk);
        #1;
        rx = {1'b0, ~rx[8:0]};
    endtask
    // raw mode only ever on socket zero
    task automatic rx_case(input logic [7:0] m, input logic [4:0] f, input logic drop);
        reopen(3'd0, m);
        pkt(3'd0, f, 1'b0);
        chk({6'h00, rx_drop, rx_acc}, {6'h00, drop, ~drop}, "filter verdict");
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        chk(status[7:0] | status[63:56], 8'h00, "status after reset");
        for (int s = 0; s < 8; s++) begin
            reg_rd(3'(s), `SMC_MODE_OFS, 8'h00);
        end
        reg_rd(3'd5, 16'h0002, 8'h00); // unmapped offset reads zero
        $display("test reset done");
    endtask
    // distinct non-protocol values prove the eight sets are independent
    task automatic t_regs();
        for (int s = 0; s < 8; s++) begin
            reg_wr(3'(s), `SMC_MODE_OFS, {1'b0, 3'(s), 4'h3});
        end
        for (int s = 0; s < 8; s++) begin
            reg_rd(3'(s), `SMC_MODE_OFS, {1'b0, 3'(s), 4'h3});
        end
        $display("test regs done");
    endtask
    task automatic t_open();
        logic [7:0] md [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
        logic [7:0] st [4] = '{8'h00, 8'h13, 8'h22, 8'h42};
        for (int i = 0; i < 4; i++) begin
            reopen(3'd0, md[i]);
            chk(status[7:0], st[i], "open state");
            reg_rd(3'd0, `SMC_STAT_OFS, st[i]); // state also readable over the host port
        end
        reg_rd(3'd0, `SMC_CMD_OFS, 8'h00); // command register never reads back
        $display("test open done");
    endtask
    task automatic t_filter();
        rx_case(8'h02, 5'b10000, 1'b0);
        rx_case(8'h42, 5'b10000, 1'b1);
        rx_case(8'h92, 5'b00001, 1'b1); // group peer address lives outside this block
        rx_case(8'h12, 5'b00001, 1'b0);
        rx_case(8'h84, 5'b00000, 1'b1); // filter on
        rx_case(8'h84, 5'b01000, 1'b0);
        rx_case(8'h84, 5'b10000, 1'b0);
        rx_case(8'h04, 5'b00000, 1'b0);
        rx_case(8'h44, 5'b10000, 1'b1);
        rx_case(8'h24, 5'b00100, 1'b1);
        rx_case(8'h14, 5'b00010, 1'b1);
        rx_case(8'hd1, 5'b10001, 1'b0);
        rx_case(8'h00, 5'b01000, 1'b1); // closed socket drops
        $display("test filter done");
    endtask
    // socket zero, so the ack checks inside the design see these segments too
    task automatic t_ack();
        int n;
        reopen(3'd0, 8'h21);
        pkt(3'd0, 5'b01001, 1'b1);
        chk(ack, 8'h01, "immediate ack");
        reg_wr(3'd0, `SMC_MODE_OFS, 8'h01);
        retry = 16'(RETRY);
        pkt(3'd0, 5'b01001, 1'b1);
        n = 1;
        while (ack === 8'h00 && n < 40) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(ack, 8'h01, "delayed ack");
        chk({7'h00, n >= RETRY * UNIT && n <= (RETRY + 1) * UNIT + 1}, 8'h01, "ack delay");
        $display("test ack done");
    endtask
    task automatic t_igmp();
        reg_wr(3'd2, `SMC_MODE_OFS, 8'ha2);
        @(posedge mclk);
        #1;
        chk(igmp, 8'h04, "igmp select");
        reg_wr(3'd2, `SMC_MODE_OFS, 8'ha1);
        @(posedge mclk);
        #1;
        chk(igmp, 8'h00, "igmp outside udp");
        $display("test igmp done");
    endtask
    // second reset in mid-run clears state and modes
    task automatic t_rerun();
        @(posedge mclk);
        #1;
        rst_n = 1'b0;
        @(posedge mclk);
        #1;
        chk(status[7:0], 8'h00, "state in reset"); // socket zero was open in tcp
        rst_n = 1'b1;
        reg_rd(3'd0, `SMC_MODE_OFS, 8'h00);
        $display("test rerun done");
    endtask
    ////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        retry = 16'h0000;
        rx = '0;
        repeat (16) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_regs();
        t_open();
        t_filter();
        t_ack();
        t_igmp();
        t_rerun();
        complete_run();
    end
endmodule
